// ==== include/smsd_pkg.sv ====
// Shared constants and types of the serial message start detector.
// Assumes one 125 MHz clock and a synchronous active-high reset.
package smsd_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets on the AHB-Lite slave
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00; // Bit 0 requests a reconfigure.
	localparam logic [7:0] ADDR_START_MASK = 8'h04; // Start condition mask.
	localparam logic [7:0] ADDR_IDLE_BITS = 8'h08; // Idle line bit times.
	localparam logic [7:0] ADDR_START_BYTE = 8'h0C; // Start character.
	localparam logic [7:0] ADDR_SEQ_MASKS = 8'h10; // Four 5-bit masks, bytes.
	localparam logic [7:0] ADDR_BAUD_DIV = 8'h14; // Clocks per bit minus one.
	localparam logic [7:0] ADDR_EXEC_STATUS = 8'h18; // Status code, read only.
	localparam logic [7:0] ADDR_STATE = 8'h1C; // Detector state, read only.
	localparam logic [2:0] ADDR_SEQ_PAGE = 3'h1; // 0x20..0x3F sequence chars.
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h40; // Sticky events, read only.
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h44; // Write one to clear.
	localparam logic [7:0] ADDR_IRQ_EN = 8'h48; // Interrupt enables.

	// ----------------------------------------------------------------
	// Condition bits, event bits, codes and counts
	// ----------------------------------------------------------------
	localparam int COND_START_CHAR = 0; // Mask value 01H.
	localparam int COND_ANY_CHAR = 1; // Mask value 02H.
	localparam int COND_BREAK = 2; // Mask value 04H.
	localparam int COND_IDLE = 3; // Mask value 08H.
	localparam int COND_SEQ0 = 4; // Sequences one to four use 10H..80H.
	localparam int IRQ_START = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_ERROR = 2;
	localparam int IRQ_ABORT = 3;
	localparam logic [7:0] LINE_KEEP = 8'h0C; // Line conditions survive errors.
	localparam logic [15:0] STATUS_OK = 16'h0000;
	localparam logic [15:0] STATUS_NO_COND = 16'h80E0; // Empty start mask.
	localparam logic [15:0] FRAME_BITS = 16'h000A; // One full character frame.
	localparam logic [15:0] BAUD_DIV_RST = 16'h0437; // 1080 clocks per bit, near 115200 baud at 125 MHz.
	localparam int SEQ_LEN = 5; // Characters per start sequence.
	localparam logic [2:0] SEQ_LAST = 3'h4; // Position of the fifth char.

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [15:0] smsd_word_t;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_ARMED = 2'b01,
		ST_MSG = 2'b10
	} smsd_st_t;

	typedef struct packed {
		logic [7:0] start_mask;
		logic [15:0] idle_bits;
		logic [7:0] start_byte;
		logic [3:0][4:0] seq_mask;
		logic [3:0][4:0][7:0] seq_chars;
	} smsd_cfg_t;

	localparam smsd_cfg_t CFG_DEFAULT = '{
		start_mask: 8'h01,
		idle_bits: 16'h0028,
		start_byte: 8'h02,
		seq_mask: '0,
		seq_chars: '0
	};

endpackage : smsd_pkg

// ==== verilog/smsd_detector.sv ====
// Receive-side message start detector with an AHB-Lite register slave.
// Assumes a character receiver in front of it that delivers checked bytes
// and the raw line level, all synchronous to i_clk.
//
// How it works
// - apply config only on request rising edge
// - reconfigure flushes every queued received message
// - success pulses done for one cycle
// - failure pulses error, status shows cause
// - 16-bit status code, zero when nothing reported
// - leaving run reloads static default configuration
// - message starts only when all selected hold
// - start mask bits 01H..80H, reset 1
// - idle line after programmed bit times
// - start byte compare, default 02H
// - five-bit compare mask per sequence
// - cleared mask bit matches any character
// - four sequences, five chars, reset zero
// - sequence masks reset to zero
// - receive error abandons start matching
// - end evaluation only after start detected
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps

module smsd_detector (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_run,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_err,
	input wire logic i_rx_line,
	input wire logic i_msg_end,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic o_cfg_done,
	output logic o_cfg_error,
	output smsd_pkg::smsd_word_t o_status,
	output logic o_queue_flush,
	output logic o_start_detected,
	output logic o_end_eval_en,
	output logic o_irq
);
	import smsd_pkg::*;

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		smsd_cfg_t pend; // Settings written by software, not yet live.
		smsd_cfg_t act; // Settings the detector is using.
		logic req; // Reconfigure request level.
		logic req_prev; // Request level one cycle ago.
		logic run_prev; // Run level one cycle ago.
		logic done; // One-cycle success pulse.
		logic err; // One-cycle failure pulse.
		logic flush; // One-cycle queue discard pulse.
		logic start; // One-cycle start detected pulse.
		logic [15:0] status; // Last execution code.
		smsd_st_t state; // Detector phase.
		logic [7:0] met; // Conditions met while armed.
		logic [3:0][2:0] seq_pos; // Next position per sequence.
		logic [15:0] div_cnt; // Bit time divider.
		logic [15:0] baud_div; // Divider reload.
		logic [15:0] idle_cnt; // Bit times of mark level.
		logic [15:0] brk_cnt; // Bit times of space level.
		logic [3:0] istat; // Sticky interrupt status.
		logic [3:0] ien; // Interrupt enables.
		logic wr; // Write data phase pending.
		logic [7:0] addr; // Address of the data phase.
		logic [31:0] rdata; // Read data for the data phase.
	} smsd_state_t;

	smsd_state_t q; // Registered state.
	smsd_state_t d; // Next state.
	logic [3:0] seq_hit; // Sequence completes on this character.
	logic [3:0][2:0] seq_npos; // Sequence position after this character.
	logic good_char; // Error-free character, not gated by state.

	assign good_char = i_rx_valid && !i_rx_err;

	// ----------------------------------------------------------------
	// Sequence matchers
	// ----------------------------------------------------------------
	// A mismatch restarts the sequence, re-trying the character at the
	// first position so that an opening starting on that character is not missed.
	// A sequence is complete once every later position is a wildcard, so
	// trailing don't-care characters need not arrive before the start.
	generate
		for (genvar s = 0; s < 4; s++) begin : g_seq
			logic m_pos; // Character fits the current position.
			logic m_first; // Character fits the first position.
			logic m_tail; // No compared position follows this one.
			assign m_pos = !q.act.seq_mask[s][q.seq_pos[s]] ||
				(q.act.seq_chars[s][q.seq_pos[s]] == i_rx_data);
			assign m_first = !q.act.seq_mask[s][0] ||
				(q.act.seq_chars[s][0] == i_rx_data);
			assign m_tail = (q.seq_pos[s] == SEQ_LAST) ||
				((q.act.seq_mask[s] >> q.seq_pos[s]) <= 5'h01);
			assign seq_hit[s] = m_pos && m_tail;
			assign seq_npos[s] = seq_hit[s] ? 3'h0 :
				m_pos ? q.seq_pos[s] + 3'h1 :
				m_first ? 3'h1 : 3'h0;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] rd;
		logic [7:0] now;
		logic [3:0] clr;
		logic [3:0] ev;
		logic tick;
		rd = 32'h0000_0000;
		now = 8'h00;
		clr = 4'h0;
		ev = 4'h0;
		tick = 1'b0;
		d = q;
		d.done = 1'b0;
		d.err = 1'b0;
		d.flush = 1'b0;
		d.start = 1'b0;

		// Write data phase; unmapped offsets are ignored.
		if (q.wr) begin
			if (q.addr == ADDR_CTRL) begin
				d.req = i_hwdata[0];
			end else if (q.addr == ADDR_START_MASK) begin
				d.pend.start_mask = i_hwdata[7:0];
			end else if (q.addr == ADDR_IDLE_BITS) begin
				d.pend.idle_bits = i_hwdata[15:0];
			end else if (q.addr == ADDR_START_BYTE) begin
				d.pend.start_byte = i_hwdata[7:0];
			end else if (q.addr == ADDR_SEQ_MASKS) begin
				for (int s = 0; s < 4; s++) begin
					d.pend.seq_mask[s] = i_hwdata[8*s +: 5];
				end
			end else if (q.addr == ADDR_BAUD_DIV) begin
				d.baud_div = i_hwdata[15:0];
			end else if (q.addr[7:5] == ADDR_SEQ_PAGE) begin
				// Even word holds chars 1..4, odd word holds char 5.
				if (q.addr[2]) begin
					d.pend.seq_chars[q.addr[4:3]][4] = i_hwdata[7:0];
				end else begin
					for (int c = 0; c < 4; c++) begin
						d.pend.seq_chars[q.addr[4:3]][c] = i_hwdata[8*c +: 8];
					end
				end
			end else if (q.addr == ADDR_IRQ_CLR) begin
				clr = i_hwdata[3:0];
			end else if (q.addr == ADDR_IRQ_EN) begin
				d.ien = i_hwdata[3:0];
			end
		end

		// Read mux, sampled in the address phase.
		if (i_haddr[7:0] == ADDR_CTRL) begin
			rd = {31'h0, q.req};
		end else if (i_haddr[7:0] == ADDR_START_MASK) begin
			rd = {24'h0, q.pend.start_mask};
		end else if (i_haddr[7:0] == ADDR_IDLE_BITS) begin
			rd = {16'h0, q.pend.idle_bits};
		end else if (i_haddr[7:0] == ADDR_START_BYTE) begin
			rd = {24'h0, q.pend.start_byte};
		end else if (i_haddr[7:0] == ADDR_SEQ_MASKS) begin
			for (int s = 0; s < 4; s++) begin
				rd[8*s +: 5] = q.pend.seq_mask[s];
			end
		end else if (i_haddr[7:0] == ADDR_BAUD_DIV) begin
			rd = {16'h0, q.baud_div};
		end else if (i_haddr[7:0] == ADDR_EXEC_STATUS) begin
			rd = {16'h0, q.status};
		end else if (i_haddr[7:0] == ADDR_STATE) begin
			rd = {22'h0, q.state, q.met};
		end else if (i_haddr[7:5] == ADDR_SEQ_PAGE) begin
			if (i_haddr[2]) begin
				rd = {24'h0, q.pend.seq_chars[i_haddr[4:3]][4]};
			end else begin
				for (int c = 0; c < 4; c++) begin
					rd[8*c +: 8] = q.pend.seq_chars[i_haddr[4:3]][c];
				end
			end
		end else if (i_haddr[7:0] == ADDR_IRQ_STAT) begin
			rd = {28'h0, q.istat};
		end else if (i_haddr[7:0] == ADDR_IRQ_EN) begin
			rd = {28'h0, q.ien};
		end

		// Address phase capture; zero wait states, so hready is ours.
		d.wr = 1'b0;
		if (i_hsel && i_htrans[1] && i_hready) begin
			d.wr = i_hwrite;
			d.addr = i_haddr[7:0];
			if (!i_hwrite) begin
				d.rdata = rd;
			end
		end

		// Bit time divider: one enable pulse per bit time.
		tick = (q.div_cnt == 16'h0000);
		d.div_cnt = tick ? q.baud_div : q.div_cnt - 16'h0001;

		// Line level timers, saturating, counted in bit times.
		if (i_rx_line) begin
			d.brk_cnt = 16'h0000;
			if (tick && q.idle_cnt != 16'hFFFF) begin
				d.idle_cnt = q.idle_cnt + 16'h0001;
			end
		end else begin
			d.idle_cnt = 16'h0000;
			if (tick && q.brk_cnt != 16'hFFFF) begin
				d.brk_cnt = q.brk_cnt + 16'h0001;
			end
		end

		// Start detection while armed; line conditions stay met once seen, character ones until a receive error.
		now[COND_BREAK] = q.brk_cnt > FRAME_BITS;
		now[COND_IDLE] = q.idle_cnt >= q.act.idle_bits;
		if (good_char) begin
			now[COND_START_CHAR] = i_rx_data == q.act.start_byte;
			now[COND_ANY_CHAR] = 1'b1;
			now[7:COND_SEQ0] = seq_hit;
		end
		now = now | q.met;
		case (q.state)
			ST_OFF: begin
				if (i_run) begin
					d.state = ST_ARMED;
					d.met = 8'h00;
					d.seq_pos = '0;
				end
			end
			ST_ARMED: begin
				d.met = now;
				if (i_rx_valid && i_rx_err) begin
					// Partial matches are dropped; line timing is kept.
					d.met = q.met & LINE_KEEP;
					d.seq_pos = '0;
					ev[IRQ_ABORT] = 1'b1;
				end else if (i_rx_valid) begin
					d.seq_pos = seq_npos;
				end
				if (!(i_rx_valid && i_rx_err) && q.act.start_mask != 8'h00 &&
					(now & q.act.start_mask) == q.act.start_mask) begin
					d.state = ST_MSG;
					d.start = 1'b1;
					ev[IRQ_START] = 1'b1;
				end
			end
			ST_MSG: begin
				if (i_msg_end) begin
					d.state = ST_ARMED;
					d.met = 8'h00;
					d.seq_pos = '0;
				end
			end
			default: begin
				d.state = ST_OFF;
			end
		endcase

		// Reconfigure on the request's rising edge only.
		d.req_prev = q.req;
		if (q.req && !q.req_prev) begin
			if (q.pend.start_mask == 8'h00) begin
				d.err = 1'b1;
				d.status = STATUS_NO_COND;
				ev[IRQ_ERROR] = 1'b1;
			end else begin
				d.act = q.pend;
				d.done = 1'b1;
				d.flush = 1'b1;
				d.status = STATUS_OK;
				d.met = 8'h00;
				d.seq_pos = '0;
				d.state = i_run ? ST_ARMED : ST_OFF;
				d.start = 1'b0;
				ev[IRQ_DONE] = 1'b1;
				ev[IRQ_START] = 1'b0;
			end
		end

		// Dynamic settings are dropped when the run phase ends.
		d.run_prev = i_run;
		if (!i_run && q.run_prev) begin
			d.act = CFG_DEFAULT;
			d.pend = CFG_DEFAULT;
			d.state = ST_OFF;
			d.start = 1'b0;
			ev[IRQ_START] = 1'b0;
		end

		// A new event wins over a clear in the same cycle.
		d.istat = (q.istat & ~clr) | ev;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			q <= '0;
			q.pend <= CFG_DEFAULT;
			q.act <= CFG_DEFAULT;
			q.baud_div <= BAUD_DIV_RST;
			q.state <= ST_OFF;
		end else begin
			q <= d;
		end
	end

	// Outputs from the state record; hreadyout and hresp are tied to constants.
	assign o_hrdata = q.rdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_cfg_done = q.done;
	assign o_cfg_error = q.err;
	assign o_status = q.status;
	assign o_queue_flush = q.flush;
	assign o_start_detected = q.start;
	assign o_end_eval_en = q.state == ST_MSG;
	assign o_irq = |(q.istat & q.ien);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	sequence s_req_rise;
		q.req && !q.req_prev;
	endsequence
	sequence s_result;
		o_cfg_done ^ o_cfg_error;
	endsequence

	property p_req_edge;
		(o_cfg_done || o_cfg_error) |-> $past(q.req) && !$past(q.req_prev);
	endproperty
	a_req_edge: assert property (p_req_edge) else $error("result w/o edge");
	property p_req_result;
		s_req_rise |=> s_result;
	endproperty
	a_req_result: assert property (p_req_result) else $error("edge no result");
	property p_flush;
		o_cfg_done |-> o_queue_flush;
	endproperty
	a_flush: assert property (p_flush) else $error("no queue flush");
	property p_done_once;
		o_cfg_done |=> !o_cfg_done;
	endproperty
	a_done_once: assert property (p_done_once) else $error("done too long");
	property p_err_code;
		o_cfg_error |-> o_status == STATUS_NO_COND ##1 !o_cfg_error;
	endproperty
	a_err_code: assert property (p_err_code) else $error("bad error code");
	property p_ok_zero;
		o_cfg_done |-> o_status == STATUS_OK;
	endproperty
	a_ok_zero: assert property (p_ok_zero) else $error("status not zero");
	property p_reload;
		$fell(i_run) |=> q.act == CFG_DEFAULT && !o_end_eval_en;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload");
	property p_all_met;
		o_start_detected |-> ($past(q.met) | q.met) != 8'h00 &&
			(q.met & q.act.start_mask) == q.act.start_mask;
	endproperty
	a_all_met: assert property (p_all_met) else $error("early start");
	property p_abort;
		(q.state == ST_ARMED && i_rx_valid && i_rx_err) |=> q.seq_pos == '0;
	endproperty
	a_abort: assert property (p_abort) else $error("match kept");
	property p_end_after;
		$rose(o_end_eval_en) |-> o_start_detected;
	endproperty
	a_end_after: assert property (p_end_after) else $error("end eval early");
	property p_mask_rst;
		$fell(i_reset) |-> q.act.seq_mask == '0 && q.act.start_mask == 8'h01;
	endproperty
	a_mask_rst: assert property (p_mask_rst) else $error("bad reset cfg");

endmodule : smsd_detector

// ==== verification/smsd_peer_model.sv ====
// Far-side serial peer: hands checked characters and the line level over.
// Assumes the bench calls its tasks right after a rising clock edge.
`timescale 1ns/1ps

module smsd_peer_model (
	input wire logic i_clk,
	output logic o_rx_valid,
	output logic [7:0] o_rx_data,
	output logic o_rx_err,
	output logic o_rx_line
);
	// ------------------------------------------------------------
	// Idle state and character delivery
	// ------------------------------------------------------------
	// Start quiet with the line at mark.
	initial begin
		o_rx_valid = 1'b0;
		o_rx_data = 8'h00;
		o_rx_err = 1'b0;
		o_rx_line = 1'b1;
	end

	// One character for one cycle; afterwards the data shows its inverse
	// so that a stale byte can never pass for a fresh one.
	task automatic send_char(input logic [7:0] b, input logic e,
		input int gap);
		o_rx_valid <= 1'b1;
		o_rx_data <= b;
		o_rx_err <= e;
		@(posedge i_clk);
		o_rx_valid <= 1'b0;
		o_rx_data <= ~b;
		o_rx_err <= ~e;
		// One edge always passes, so valid is never driven twice at once.
		repeat (gap + 1) @(posedge i_clk);
	endtask : send_char

	// Sets the line level, 1 is mark and 0 is space.
	task automatic set_line(input logic l);
		o_rx_line <= l;
		@(posedge i_clk);
	endtask : set_line
endmodule : smsd_peer_model

// ==== verification/tb_smsd_detector.sv ====
// Self-checking bench of the start detector: AHB-Lite master, peer model.
// Assumes one 8 ns clock and a synchronous active-high reset.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_smsd_detector;
	import smsd_pkg::*;
	// ------------------------------------------------------------
	// Signals and bookkeeping
	// ------------------------------------------------------------
	logic i_clk, i_reset, run, msg_end, hsel, hwrite, hready, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic done, err, flush, start, en_eval, irq, rx_v, rx_e, rx_l;
	logic [7:0] rx_d, b;
	smsd_word_t status, exp_st;
	logic [19:0] notes[$]; // Expected {status, flush, err, done, start}.
	logic [19:0] want;
	int fails, compares, cyc, i, s;
	logic [7:0] ra[8] = '{ADDR_START_MASK, ADDR_IDLE_BITS, ADDR_START_BYTE,
		ADDR_SEQ_MASKS, 8'h20, 8'h3C, ADDR_EXEC_STATUS, 8'h4C};
	logic [31:0] rv[8] = '{32'h00000001, 32'h00000028, 32'h00000002,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

	smsd_detector u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_run(run),
		.i_rx_valid(rx_v), .i_rx_data(rx_d), .i_rx_err(rx_e),
		.i_rx_line(rx_l), .i_msg_end(msg_end), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.o_cfg_done(done), .o_cfg_error(err), .o_status(status),
		.o_queue_flush(flush), .o_start_detected(start),
		.o_end_eval_en(en_eval), .o_irq(irq));
	smsd_peer_model u_peer (.i_clk(i_clk), .o_rx_valid(rx_v),
		.o_rx_data(rx_d), .o_rx_err(rx_e), .o_rx_line(rx_l));

	// Free-running 125 MHz clock.
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	// One single word transfer; waits on hready, never on a fixed count.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge i_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge i_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	// Reads one register and compares it.
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(rd, e)
		`CHK(hresp, 1'b0)
	endtask : chk_rd

	// Waits until every note is met, then confirms nothing stays open.
	task automatic drain();
		int k;
		for (k = 0; k < 400 && notes.size() != 0; k++) @(posedge i_clk);
		repeat (4) @(posedge i_clk);
		`CHK(notes.size(), 0)
	endtask : drain

	// Applies a configuration; the request is written high twice so a
	// level that merely stays high is seen to do nothing.
	task automatic cfg(input logic [7:0] m, input logic [15:0] it,
		input logic [7:0] sb, input logic st);
		bus(1'b1, ADDR_START_MASK, {24'h000000, m});
		bus(1'b1, ADDR_IDLE_BITS, {16'h0000, it});
		bus(1'b1, ADDR_START_BYTE, {24'h000000, sb});
		exp_st = (m == 8'h00) ? STATUS_NO_COND : STATUS_OK;
		notes.push_back({exp_st, m != 8'h00, m == 8'h00, m != 8'h00, 1'b0});
		if (st) notes.push_back({exp_st, 4'h1});
		bus(1'b1, ADDR_CTRL, 32'h00000001);
		bus(1'b1, ADDR_CTRL, 32'h00000001);
		bus(1'b1, ADDR_CTRL, 32'h00000000);
		drain();
	endtask : cfg

	// Closes a message: end evaluation must run and then stop.
	task automatic end_msg();
		`CHK(en_eval, 1'b1)
		msg_end <= 1'b1;
		@(posedge i_clk);
		msg_end <= 1'b0;
		repeat (2) @(posedge i_clk);
		`CHK(en_eval, 1'b0)
	endtask : end_msg

	// Sends a character that completes a start, then closes the message.
	task automatic hit(input logic [7:0] c);
		notes.push_back({exp_st, 4'h1});
		u_peer.send_char(c, 1'b0, 0);
		drain();
		end_msg();
	endtask : hit

	task automatic tdone(input string n);
		$display("test %s done", n);
	endtask : tdone

	task automatic print_verdict();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	// ------------------------------------------------------------
	// Result watcher and hang guard
	// ------------------------------------------------------------
	// Every result pulse takes the oldest note; an unexpected one fails.
	always @(posedge i_clk) begin
		cyc++;
		if (!i_reset && (start | done | err) !== 1'b0) begin
			want = (notes.size() != 0) ? notes.pop_front() : 20'h00000;
			`CHK({status, flush, err, done, start}, want)
		end
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		i_reset = 1'b1;
		{run, msg_end, hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		{fails, compares, cyc} = '0;
		exp_st = STATUS_OK;
		void'($urandom(32'h8078BA93));
		repeat (2) @(posedge i_clk);
		i_reset <= 1'b0;
		run <= 1'b1;
		for (i = 0; i < 8; i++) chk_rd(ra[i], rv[i]);
		`CHK(irq, 1'b0)
		u_peer.send_char(8'h03, 1'b0, 0);
		drain();
		hit(8'h02);
		tdone("defaults");
		bus(1'b1, ADDR_BAUD_DIV, 32'h00000001);
		// The divider reloads only when its old count runs out.
		repeat (int'(BAUD_DIV_RST) + 2) @(posedge i_clk);
		cfg(8'h08, 16'h0003, 8'h02, 1'b1);
		u_peer.set_line(1'b0);
		end_msg();
		cfg(8'h04, 16'h0003, 8'h02, 1'b1);
		u_peer.set_line(1'b1);
		end_msg();
		tdone("line conditions");
		bus(1'b1, ADDR_IRQ_CLR, 32'h0000000F);
		bus(1'b1, ADDR_IRQ_EN, 32'h00000004);
		cfg(8'h00, 16'h0028, 8'h02, 1'b0);
		`CHK(irq, 1'b1)
		chk_rd(ADDR_IRQ_STAT, 32'h00000004);
		bus(1'b1, ADDR_IRQ_EN, 32'h00000000);
		@(posedge i_clk);
		`CHK(irq, 1'b0)
		bus(1'b1, ADDR_IRQ_CLR, 32'h00000004);
		@(posedge i_clk);
		chk_rd(ADDR_IRQ_STAT, 32'h00000000);
		tdone("refused request");
		// Sequence one compares chars 1 and 4 only; 2 and 3 are random.
		bus(1'b1, ADDR_SEQ_MASKS, 32'h00000009);
		bus(1'b1, 8'h20, 32'h68000068);
		cfg(8'h10, 16'h0028, 8'h02, 1'b0);
		notes.push_back({exp_st, 4'h1});
		u_peer.send_char(8'h68, 1'b0, $urandom_range(0, 2));
		u_peer.send_char(8'($urandom), 1'b0, $urandom_range(0, 2));
		u_peer.send_char(8'($urandom), 1'b0, $urandom_range(0, 2));
		u_peer.send_char(8'h68, 1'b0, 0);
		drain();
		end_msg();
		u_peer.send_char(8'h68, 1'b0, 0);
		u_peer.send_char(8'($urandom), 1'b1, 1);
		u_peer.send_char(8'($urandom), 1'b0, 0);
		u_peer.send_char(8'h68, 1'b0, 0);
		drain();
		for (s = 1; s < 4; s++) begin
			b = 8'($urandom);
			bus(1'b1, ADDR_SEQ_MASKS, 32'h00000001 << (8 * s));
			bus(1'b1, 8'(8'h20 + 8 * s), {24'h000000, b});
			cfg(8'(8'h10 << s), 16'h0028, 8'h02, 1'b0);
			hit(b);
		end
		tdone("sequences");
		cfg(8'h03, 16'h0028, 8'h02, 1'b0);
		u_peer.send_char(8'h55, 1'b0, 0);
		drain();
		hit(8'h02);
		tdone("combined");
		cfg(8'h01, 16'h0028, 8'h33, 1'b0);
		run <= 1'b0;
		@(posedge i_clk);
		run <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk_rd(ADDR_START_BYTE, 32'h00000002);
		u_peer.send_char(8'h33, 1'b0, 0);
		drain();
		hit(8'h02);
		tdone("run reload");
		print_verdict();
	end
endmodule : tb_smsd_detector
